// File: core/stm_timer.sv
`timescale 1ns/10ps
module stm_timer
  import stm_pkg::*;
(
  input  wire logic        CLK_SYS,       // system clock 200 MHz
  input  wire logic        RST,           // sync reset, high
  input  wire logic [3:0]  ADDRESS,       // word address
  input  wire logic        READ,          // read strobe
  input  wire logic        WRITE,         // write strobe
  input  wire logic [31:0] WRITEDATA,     // write data
  input  wire logic [3:0]  BYTEENABLE,    // byte lanes
  output logic      [31:0] READDATA,      // read data
  output logic             WAITREQUEST,   // stall
  input  wire logic        EXT_CLK_PIN,   // external clock pin
  input  wire logic        CAPTURE_PIN,   // capture input pin
  output logic             TIMER_OUT,     // timer output pin
  output logic             TIMER_OUT_EN,  // output pin drive enable
  output logic             IRQ_REQ        // one-cycle request pulse
);
  stm_ctrl0_s  ctrl0_q;
  stm_ctrl1_s  ctrl1_q;
  logic [15:0] cmp_q;
  logic [7:0]  per_q;
  logic [15:0] cnt_q;
  logic [1:0]  div4_q;
  logic [3:0]  h16_q;
  logic [5:0]  h64_q;
  logic [9:0]  tbc_q;
  logic [2:0]  ext_q;
  logic [2:0]  cap_q;
  logic        on_prev_q;
  logic        lvl_q;
  logic        pwm_q;
  stm_sp_e     sp_q;
  logic [1:0]  flags_q;
  logic        rd_ack_q;
  logic        wr_ack_q;
  logic        tick;
  logic        on_rise;
  logic        match_a;
  logic        match_p;
  logic        ovf;
  logic        clr;
  logic        wr_go;
  logic        rd_go;
  logic        cap_ev;
  logic [15:0] period_end;
  logic [15:0] duty_end;
  logic        drive_lvl;
  logic        act;
  logic        act_full;

  // internal clock dividers for selectable rates
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      div4_q <= 2'h0;
      h16_q  <= 4'h0;
      h64_q  <= 6'h0;
      tbc_q  <= 10'h000;
    end else begin
      div4_q <= div4_q + 2'h1;
      h16_q  <= (h16_q == STM_HDIV16) ? 4'h0 : h16_q + 4'h1;
      h64_q  <= (h64_q == STM_HDIV64) ? 6'h00 : h64_q + 6'h01;
      tbc_q  <= (tbc_q == STM_TBC_DIV) ? 10'h000 : tbc_q + 10'h001;
    end
  end

  // pin synchronisers, third stage for edges
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      ext_q <= 3'h0;
      cap_q <= 3'h0;
    end else begin
      ext_q <= {ext_q[1:0], EXT_CLK_PIN};
      cap_q <= {cap_q[1:0], CAPTURE_PIN};
    end
  end

  // clock source select to a count enable
  always_comb begin
    case (ctrl0_q.clock_select_field)
      3'h0:    tick = (div4_q == 2'h3);
      3'h1:    tick = 1'b1;
      3'h2:    tick = (h16_q == STM_HDIV16);
      3'h3:    tick = (h64_q == STM_HDIV64);
      3'h4:    tick = (tbc_q == STM_TBC_DIV);
      3'h6:    tick = ext_q[1] & ~ext_q[2];
      3'h7:    tick = ~ext_q[1] & ext_q[2];
      default: tick = 1'b0;
    endcase
  end

  // comparators and clear selection
  assign on_rise = ctrl0_q.module_on_bit & ~on_prev_q;
  assign match_a = (cnt_q == cmp_q);
  assign match_p = (per_q != 8'h00) && (cnt_q[15:8] == per_q) &&
                   (cnt_q[7:0] == 8'h00);
  assign ovf     = (cnt_q == 16'hFFFF);
  assign act     = ctrl0_q.module_on_bit & ~ctrl0_q.pause_bit & tick;
  assign period_end = ctrl1_q.duty_period_swap_bit ? cmp_q :
                      {per_q, 8'h00};
  assign duty_end   = ctrl1_q.duty_period_swap_bit ? {per_q, 8'h00} :
                      cmp_q;
  always_comb begin
    if (ctrl1_q.mode == STM_PWM) begin
      clr = (period_end == 16'h0000) ? ovf :
            (cnt_q == period_end - 16'h0001);
    end else if (ctrl1_q.mode == STM_CAP) begin
      clr = ovf;
    end else if (ctrl1_q.clear_select_bit) begin
      clr = match_a | ovf;
    end else begin
      clr = (per_q == 8'h00) ? ovf :
            (cnt_q == {per_q, 8'h00} - 16'h0001);
    end
  end

  // capture edge select
  always_comb begin
    case (ctrl1_q.pin_function)
      2'h0:    cap_ev = cap_q[1] & ~cap_q[2];
      2'h1:    cap_ev = ~cap_q[1] & cap_q[2];
      2'h2:    cap_ev = cap_q[1] ^ cap_q[2];
      default: cap_ev = 1'b0;
    endcase
  end

  // counter, cleared only by hardware or on-bit rise
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      cnt_q     <= 16'h0000;
      on_prev_q <= 1'b0;
    end else begin
      on_prev_q <= ctrl0_q.module_on_bit;
      if (on_rise) begin
        cnt_q <= 16'h0000;
      end else if (act) begin
        cnt_q <= clr ? 16'h0000 : cnt_q + 16'h0001;
      end
    end
  end

  // interrupt request pulse; sticky match flags are set in the register write block
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      IRQ_REQ <= 1'b0;
    end else begin
      IRQ_REQ <= act & (clr | match_a | match_p | ovf) |
                 (ctrl0_q.module_on_bit & cap_ev &
                  (ctrl1_q.mode == STM_CAP));
    end
  end

  // compare output level and single pulse state
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      lvl_q <= 1'b0;
      sp_q  <= STM_SP_IDLE;
    end else if (on_rise) begin
      lvl_q <= ctrl1_q.output_control_bit;
      sp_q  <= STM_SP_ACT;
    end else begin
      if (act && match_a && ctrl1_q.mode == STM_CMP) begin
        case (ctrl1_q.pin_function)
          2'h1:    lvl_q <= 1'b0;
          2'h2:    lvl_q <= 1'b1;
          2'h3:    lvl_q <= ~lvl_q;
          default: lvl_q <= lvl_q;
        endcase
      end
      case (sp_q)
        STM_SP_ACT: if (act && (cnt_q == duty_end - 16'h0001 ||
                                duty_end == 16'h0000))
          sp_q <= STM_SP_DONE;
        STM_SP_DONE: sp_q <= STM_SP_DONE;
        default:     sp_q <= STM_SP_IDLE;
      endcase
    end
  end

  // pwm active phase, full duty when duty at or above period
  always_comb begin
    if (period_end != 16'h0000 && duty_end >= period_end) begin
      act_full = 1'b1;
    end else begin
      act_full = 1'b0;
    end
  end
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      pwm_q <= 1'b0;
    end else begin
      pwm_q <= act_full | (cnt_q < duty_end);
    end
  end

  // pin level per mode, then polarity
  always_comb begin
    case (ctrl1_q.mode)
      STM_CMP: drive_lvl = lvl_q;
      STM_PWM: begin
        case (ctrl1_q.pin_function)
          2'h0:    drive_lvl = ~ctrl1_q.output_control_bit;
          2'h1:    drive_lvl = ctrl1_q.output_control_bit;
          2'h2:    drive_lvl = pwm_q ~^ ctrl1_q.output_control_bit;
          default: drive_lvl = (sp_q == STM_SP_ACT) ~^
                               ctrl1_q.output_control_bit;
        endcase
      end
      default: drive_lvl = 1'b0;
    endcase
  end
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      TIMER_OUT    <= 1'b0;
      TIMER_OUT_EN <= 1'b0;
    end else begin
      TIMER_OUT    <= (ctrl1_q.mode == STM_TMR) ? 1'b0 :
                      drive_lvl ^ ctrl1_q.output_polarity_bit;
      TIMER_OUT_EN <= (ctrl1_q.mode == STM_CMP) ||
                      (ctrl1_q.mode == STM_PWM);
    end
  end

  // bus handshake: one wait cycle then acknowledge
  assign wr_go = WRITE & wr_ack_q;
  assign rd_go = READ & rd_ack_q;
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      wr_ack_q    <= 1'b0;
      rd_ack_q    <= 1'b0;
      WAITREQUEST <= 1'b1;
    end else begin
      wr_ack_q    <= WRITE & ~wr_ack_q;
      rd_ack_q    <= READ & ~rd_ack_q;
      WAITREQUEST <= ~((WRITE & ~wr_ack_q) | (READ & ~rd_ack_q));
    end
  end

  // register writes; counter has no write path
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      ctrl0_q <= '0;
      ctrl1_q <= '0;
      cmp_q   <= {STM_RST_BYTE, STM_RST_BYTE};
      per_q   <= STM_RST_BYTE;
      flags_q <= 2'h0;
    end else begin
      if (wr_go && BYTEENABLE[0]) begin
        case (ADDRESS)
          STM_OFS_CMP_LO: cmp_q[7:0]  <= WRITEDATA[7:0];
          STM_OFS_CMP_HI: cmp_q[15:8] <= WRITEDATA[7:0];
          STM_OFS_CTRL0:  ctrl0_q     <= WRITEDATA[7:3];
          STM_OFS_CTRL1:  ctrl1_q     <= WRITEDATA[7:0];
          STM_OFS_PER:    per_q       <= WRITEDATA[7:0];
          default:        ;
        endcase
      end
      // sticky match flags, set wins over clear
      flags_q <= ((wr_go && BYTEENABLE[0] && ADDRESS == STM_OFS_STAT) ?
                  flags_q & ~WRITEDATA[1:0] : flags_q) |
                 {act & match_p, act & match_a};
    end
  end

  // read mux
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      READDATA <= 32'h0000_0000;
    end else if (READ & ~rd_ack_q) begin
      case (ADDRESS)
        STM_OFS_CNT_LO: READDATA <= {24'h0, cnt_q[7:0]};
        STM_OFS_CNT_HI: READDATA <= {24'h0, cnt_q[15:8]};
        STM_OFS_CMP_LO: READDATA <= {24'h0, cmp_q[7:0]};
        STM_OFS_CMP_HI: READDATA <= {24'h0, cmp_q[15:8]};
        STM_OFS_CTRL0:  READDATA <= {24'h0, ctrl0_q, 3'h0};
        STM_OFS_CTRL1:  READDATA <= {24'h0, ctrl1_q};
        STM_OFS_PER:    READDATA <= {24'h0, per_q};
        STM_OFS_STAT:   READDATA <= {30'h0, flags_q};
        default:        READDATA <= 32'h0000_0000;
      endcase
    end
  end

  // checks
  property p_on_zero;
    @(posedge CLK_SYS) disable iff (RST)
      on_rise |=> (cnt_q == 16'h0000);
  endproperty
  a_on_zero: assert property (p_on_zero) else $error("on rise no zero");
  property p_pause;
    @(posedge CLK_SYS) disable iff (RST)
      (ctrl0_q.pause_bit && !on_rise) |=> $stable(cnt_q);
  endproperty
  a_pause: assert property (p_pause)
    else $error("count moved in pause");
  property p_off_hold;
    @(posedge CLK_SYS) disable iff (RST)
      (!ctrl0_q.module_on_bit) |=> $stable(cnt_q);
  endproperty
  a_off_hold: assert property (p_off_hold)
    else $error("count moved off");
  property p_clr;
    @(posedge CLK_SYS) disable iff (RST)
      (act && clr && !on_rise) |=> (cnt_q == 16'h0000) && IRQ_REQ;
  endproperty
  a_clr: assert property (p_clr) else $error("clear missed");
  property p_inc;
    @(posedge CLK_SYS) disable iff (RST)
      (act && !clr && !on_rise) |=> (cnt_q == $past(cnt_q) + 16'h0001);
  endproperty
  a_inc: assert property (p_inc) else $error("no increment");
  property p_tmr_off;
    @(posedge CLK_SYS) disable iff (RST)
      (ctrl1_q.mode == STM_TMR) |=> !TIMER_OUT_EN;
  endproperty
  a_tmr_off: assert property (p_tmr_off)
    else $error("pin on in timer");
  property p_init;
    @(posedge CLK_SYS) disable iff (RST)
      on_rise |=> (lvl_q == $past(ctrl1_q.output_control_bit));
  endproperty
  a_init: assert property (p_init) else $error("initial level lost");
  property p_reserved;
    @(posedge CLK_SYS) disable iff (RST)
      (ctrl0_q.clock_select_field == 3'h5) |-> !tick;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved ticks");
  property p_c0_read;
    @(posedge CLK_SYS) disable iff (RST)
      (READ && !rd_ack_q && ADDRESS == STM_OFS_CTRL0) |=>
        READDATA[2:0] == 3'h0;
  endproperty
  a_c0_read: assert property (p_c0_read) else $error("low bits set");
  // forced pwm level and compare drive-high action
  sequence s_pwm_forced;
    ctrl1_q.mode == STM_PWM && ctrl1_q.pin_function == 2'h1;
  endsequence
  property p_forced_active;
    @(posedge CLK_SYS) disable iff (RST)
      s_pwm_forced |=> TIMER_OUT == ($past(ctrl1_q.output_control_bit) ^
                                     $past(ctrl1_q.output_polarity_bit));
  endproperty
  a_forced_active: assert property (p_forced_active)
    else $error("forced level wrong");
  property p_match_high;
    @(posedge CLK_SYS) disable iff (RST)
      (act && match_a && !on_rise && ctrl1_q.mode == STM_CMP &&
       ctrl1_q.pin_function == 2'h2) |=> lvl_q;
  endproperty
  a_match_high: assert property (p_match_high)
    else $error("match did not drive high");
endmodule

// File: core/stm_pkg.sv
package stm_pkg;
  localparam logic [3:0] STM_OFS_CNT_LO = 4'h0;
  localparam logic [3:0] STM_OFS_CNT_HI = 4'h1;
  localparam logic [3:0] STM_OFS_CMP_LO = 4'h2;
  localparam logic [3:0] STM_OFS_CMP_HI = 4'h3;
  localparam logic [3:0] STM_OFS_CTRL0  = 4'h4;
  localparam logic [3:0] STM_OFS_CTRL1  = 4'h5;
  localparam logic [3:0] STM_OFS_PER    = 4'h6;
  localparam logic [3:0] STM_OFS_STAT   = 4'h7;
  localparam logic [7:0] STM_RST_BYTE   = 8'h00;
  localparam logic [7:0] STM_CTRL0_MASK = 8'hF8;
  localparam logic [3:0] STM_HDIV16     = 4'hF;
  localparam logic [5:0] STM_HDIV64     = 6'h3F;
  localparam logic [9:0] STM_TBC_DIV    = 10'h3FF;
  typedef enum logic [1:0] {
    STM_CMP = 2'b00, STM_CAP = 2'b01, STM_PWM = 2'b10, STM_TMR = 2'b11
  } stm_mode_e;
  typedef enum logic [1:0] {
    STM_SP_IDLE = 2'b00, STM_SP_ACT = 2'b01, STM_SP_DONE = 2'b11
  } stm_sp_e;
  typedef struct packed {
    logic       pause_bit;
    logic [2:0] clock_select_field;
    logic       module_on_bit;
  } stm_ctrl0_s;
  typedef struct packed {
    stm_mode_e  mode;
    logic [1:0] pin_function;
    logic       output_control_bit;
    logic       output_polarity_bit;
    logic       duty_period_swap_bit;
    logic       clear_select_bit;
  } stm_ctrl1_s;
endpackage

// File: tb/stm_pins_model.sv
`timescale 1ns/10ps
// pin-side partner: drives the external count clock and capture pins
module stm_pins_model
  import stm_pkg::*;
(
  input  wire logic clk_sys, // system clock
  input  wire logic rst,     // sync reset, high
  input  wire logic run,     // let the count clock toggle
  input  wire logic cap_lvl, // requested capture pin level
  output logic      ext_clk, // external count clock pin
  output logic      cap_pin  // capture input pin
);
  logic [1:0] div_q;

  // slow count clock, each level held four system cycles
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      div_q   <= 2'h0;
      ext_clk <= 1'b0;
    end else if (run) begin
      div_q <= div_q + 2'h1;
      if (div_q == 2'h3) ext_clk <= ~ext_clk;
    end
  end

  // capture pin follows the bench request one cycle later
  always_ff @(posedge clk_sys) begin
    if (rst) cap_pin <= 1'b0;
    else cap_pin <= cap_lvl;
  end
endmodule

// File: tb/stm_timer_tb.sv
`timescale 1ns/10ps
module stm_timer_tb;
  import stm_pkg::*;
  logic        clk_sys, rst, rd, wr, run, cap, ext_clk, cap_pin;
  logic        wait_rq, t_out, t_en, irq, oc, pol;
  logic [3:0]  adr;
  logic [31:0] wdat, rdat;
  logic [7:0]  q, wd;
  logic [15:0] c1, c2;
  int          n_fail, n_tests, n_irq, n_rise, n_fall, seed, hi;
  int          pa[7] = '{64, 64, 512, 100, 64, 64, 64};
  int          pio[7] = '{2, 2, 2, 2, 0, 1, 3};
  int          pe[7] = '{128, 384, 512, 512, 0, 512, 0};
  int          ce[4] = '{1, 1, 2, 0};

  stm_timer u_dut (.CLK_SYS(clk_sys), .RST(rst), .ADDRESS(adr), .READ(rd),
    .WRITE(wr), .WRITEDATA(wdat), .BYTEENABLE(4'hF), .READDATA(rdat),
    .WAITREQUEST(wait_rq), .EXT_CLK_PIN(ext_clk), .CAPTURE_PIN(cap_pin),
    .TIMER_OUT(t_out), .TIMER_OUT_EN(t_en), .IRQ_REQ(irq));
  stm_pins_model u_pins (.clk_sys(clk_sys), .rst(rst), .run(run),
    .cap_lvl(cap), .ext_clk(ext_clk), .cap_pin(cap_pin));

  // clock and event counters
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) if (irq === 1'b1) n_irq++;
  always @(posedge ext_clk) n_rise++;
  always @(negedge ext_clk) n_fall++;

  task chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task chkr(input int v, input int lo, input int hi_b, input string m);
    chk({15'h0, v >= lo && v <= hi_b}, 16'h1, m);
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // one bus access, held until waitrequest is seen low
  task bus(input bit w, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    adr <= a;
    wr <= w;
    rd <= !w;
    wdat <= {24'h0, d};
    do begin
      @(posedge clk_sys);
    end while (wait_rq !== 1'b0);
    q = rdat[7:0];
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task rdcnt(output logic [15:0] c);
    bus(0, STM_OFS_CNT_LO, 8'h00);
    c[7:0] = q;
    bus(0, STM_OFS_CNT_HI, 8'h00);
    c[15:8] = q;
  endtask
  task setab(input logic [15:0] a, input logic [7:0] p);
    bus(1, STM_OFS_CMP_LO, a[7:0]);
    bus(1, STM_OFS_CMP_HI, a[15:8]);
    bus(1, STM_OFS_PER, p);
  endtask
  // switch off, set mode and pins, then switch on with a rising edge
  task start(input logic [2:0] ck, input logic [7:0] m);
    bus(1, STM_OFS_CTRL0, 8'h00);
    bus(1, STM_OFS_CTRL1, m);
    bus(1, STM_OFS_CTRL0, {1'b0, ck, 4'h8});
  endtask
  function logic pin_exp(input int io, input logic oc_i);
    case (io)
      0: return oc_i;
      1: return 1'b0;
      2: return 1'b1;
      default: return !oc_i;
    endcase
  endfunction
  task summarize;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // watchdog
  initial begin
    repeat (40000) @(posedge clk_sys);
    n_fail++;
    summarize;
  end

  initial begin
    seed = 52831;
    {rst, rd, wr, run, cap, adr, wdat} = {5'h10, 4'h0, 32'h0};
    cyc(10);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      bus(0, i[3:0], 8'h00);
      chk({8'h00, q}, 16'h0000, "reset value");
    end
    bus(0, 4'hC, 8'h00);
    chk({8'h00, q}, 16'h0000, "unmapped read");
    bus(1, STM_OFS_CTRL0, 8'hFF);
    bus(0, STM_OFS_CTRL0, 8'h00);
    chk({8'h00, q}, 16'h00F8, "ctrl0 low bits");
    bus(1, STM_OFS_CTRL0, 8'h00);
    for (int i = 2; i < 7; i++) if (i != 4) begin
      wd = $random(seed);
      bus(1, i[3:0], wd);
      bus(0, i[3:0], 8'h00);
      chk({8'h00, q}, {8'h00, wd}, "readback");
    end
    $display("test registers done");
    setab(16'hFFFF, 8'h00);
    start(3'b001, 8'hC1);
    cyc(50);
    bus(1, STM_OFS_CTRL0, 8'h98);
    rdcnt(c1);
    cyc(20);
    rdcnt(c2);
    chk(c2, c1, "pause hold");
    chkr(c1, 40, 80, "count rate");
    bus(1, STM_OFS_CNT_LO, 8'h55);
    rdcnt(c2);
    chk(c2, c1, "count write");
    bus(1, STM_OFS_CTRL0, 8'h18);
    cyc(20);
    bus(1, STM_OFS_CTRL0, 8'h10);
    rdcnt(c1);
    chkr(c1, c2 + 20, c2 + 40, "resume");
    cyc(20);
    rdcnt(c2);
    chk(c2, c1, "off hold");
    bus(1, STM_OFS_CTRL0, 8'h18);
    cyc(4);
    rdcnt(c1);
    chkr(c1, 1, 12, "on rise zero");
    bus(1, STM_OFS_CTRL0, 8'h58);
    rdcnt(c1);
    cyc(20);
    rdcnt(c2);
    chk(c2, c1, "reserved clock");
    chk(t_en, 1'b0, "timer mode pin");
    for (int j = 0; j < 2; j++) begin
      start({2'b11, j[0]}, 8'hC1);
      n_rise = 0;
      n_fall = 0;
      run <= 1'b1;
      cyc(80);
      run <= 1'b0;
      cyc(10);
      rdcnt(c1);
      chk(c1, j ? n_fall[15:0] : n_rise[15:0], "pin edges");
    end
    $display("test counting done");
    setab(16'h0009, 8'h00);
    start(3'b001, 8'hC1);
    n_irq = 0;
    cyc(200);
    chkr(n_irq, 19, 21, "compare clear");
    setab(16'hFFFF, 8'h01);
    start(3'b001, 8'hC0);
    n_irq = 0;
    cyc(1024);
    chkr(n_irq, 3, 5, "period clear");
    $display("test clearing done");
    setab(16'd20, 8'h00);
    for (int i = 0; i < 4; i++) begin
      oc = $random(seed);
      pol = $random(seed);
      start(3'b001, {2'b00, i[1:0], oc, pol, 2'b01});
      cyc(3);
      chk(t_out, oc ^ pol, "initial level");
      chk(t_en, 1'b1, "pin driven");
      cyc(27);
      chk(t_out, pin_exp(i, oc) ^ pol, "match action");
    end
    $display("test compare output done");
    for (int i = 0; i < 4; i++) begin
      start(3'b101, {2'b01, i[1:0], 4'h0});
      n_irq = 0;
      cap <= 1'b1;
      cyc(10);
      cap <= 1'b0;
      cyc(10);
      chk(n_irq[15:0], ce[i][15:0], "capture edges");
    end
    $display("test capture done");
    for (int k = 0; k < 7; k++) begin
      setab(pa[k][15:0], 8'h01);
      start(3'b001, {2'b10, pio[k][1:0], 1'b1, k == 1, k == 3, 1'b1});
      cyc(300);
      hi = 0;
      repeat (512) begin
        @(posedge clk_sys);
        if (t_out === 1'b1) hi++;
      end
      chkr(hi, pe[k] - 2, pe[k] + 2, "pwm duty");
    end
    $display("test pwm done");
    summarize;
  end
endmodule
